// [common/dpm_pkg.sv]
// Constants shared by the dual-output modulator and its tick generator
package dpm_pkg;
    // ==========================================
    // Register addresses on the core's register bus
    localparam logic [7:0] CTRL_ADDR = 8'hae;
    localparam logic [7:0] DUTY0_LO_ADDR = 8'hb1;
    localparam logic [7:0] DUTY0_HI_ADDR = 8'hb2;
    localparam logic [7:0] DUTY1_LO_ADDR = 8'hb3;
    localparam logic [7:0] DUTY1_HI_ADDR = 8'hb4;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // ==========================================
    // Control field positions
    localparam int FIRST_OFF_BIT = 7;
    localparam int MODE_LSB = 4;
    localparam int PRESC_LSB = 2;
    localparam int CSRC_LSB = 0;
    // ==========================================
    // Mode codes
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_SINGLE = 3'h1;
    localparam logic [2:0] MODE_TWIN8 = 3'h2;
    localparam logic [2:0] MODE_TWIN16 = 3'h3;
    localparam logic [2:0] MODE_SD_NRZ = 3'h4;
    localparam logic [2:0] MODE_DUAL8 = 3'h5;
    localparam logic [2:0] MODE_SD_RZ = 3'h6;
    localparam logic [2:0] MODE_RESERVED = 3'h7;
    // ==========================================
    // Clock source and prescaler codes
    localparam logic [1:0] CSRC_DIV15 = 2'h0;
    localparam logic [1:0] CSRC_DIVIDED = 2'h1;
    localparam logic [1:0] CSRC_EXTERNAL = 2'h2;
    localparam logic [1:0] CSRC_RAW = 2'h3;
    localparam logic [3:0] DIV15_LAST = 4'he;
    localparam logic [1:0] PRESC_1 = 2'h0;
    localparam logic [1:0] PRESC_4 = 2'h1;
    localparam logic [1:0] PRESC_16 = 2'h2;
    localparam logic [5:0] PRESC_LAST_1 = 6'h00;
    localparam logic [5:0] PRESC_LAST_4 = 6'h03;
    localparam logic [5:0] PRESC_LAST_16 = 6'h0f;
    localparam logic [5:0] PRESC_LAST_64 = 6'h3f;
    localparam logic [15:0] CNT_FULL_LAST = 16'hffff;
    localparam logic [15:0] ONE16 = 16'h0001;
endpackage

// [common/dpm_clk_if.sv]
// Clock selection and tick carrier between modulator core and tick generator
interface dpm_clk_if;
    logic [1:0] clock_source;
    logic [1:0] prescale;
    logic restart;
    logic tick;
    modport gen (input clock_source, input prescale, input restart, output tick);
    modport user (output clock_source, output prescale, output restart, input tick);
endinterface

// [rtl/dpm_tick_gen.sv]
// Clock source selection and prescaler producing the counter tick
module dpm_tick_gen (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ext_count_input,
    input wire logic core_div_tick,
    dpm_clk_if.gen ckif
);
    typedef struct packed {
        logic [3:0] src_cnt;
        logic [5:0] pre_cnt;
        logic [2:0] sync;
    } dpm_tick_state_type;

    dpm_tick_state_type s_r;
    dpm_tick_state_type s_nxt;
    logic src_tick;
    logic [5:0] pre_last;

    // ==========================================
    // Source select, then prescale
    always_comb begin
        s_nxt = s_r;
        s_nxt.sync = {s_r.sync[1:0], ext_count_input};
        unique case (ckif.clock_source)
            dpm_pkg::CSRC_DIV15: src_tick = core_div_tick && (s_r.src_cnt == dpm_pkg::DIV15_LAST);
            dpm_pkg::CSRC_DIVIDED: src_tick = core_div_tick;
            // Edge taken from the second and third stages only
            dpm_pkg::CSRC_EXTERNAL: src_tick = s_r.sync[1] && !s_r.sync[2];
            default: src_tick = 1'b1;
        endcase
        unique case (ckif.prescale)
            dpm_pkg::PRESC_1: pre_last = dpm_pkg::PRESC_LAST_1;
            dpm_pkg::PRESC_4: pre_last = dpm_pkg::PRESC_LAST_4;
            dpm_pkg::PRESC_16: pre_last = dpm_pkg::PRESC_LAST_16;
            default: pre_last = dpm_pkg::PRESC_LAST_64;
        endcase
        if (core_div_tick) begin
            s_nxt.src_cnt = (s_r.src_cnt == dpm_pkg::DIV15_LAST) ? 4'h0 : s_r.src_cnt + 4'h1;
        end
        if (src_tick) begin
            s_nxt.pre_cnt = (s_r.pre_cnt == pre_last) ? 6'h00 : s_r.pre_cnt + 6'h01;
        end
        if (ckif.restart) begin
            s_nxt.src_cnt = 4'h0;
            s_nxt.pre_cnt = 6'h00;
        end
    end

    assign ckif.tick = src_tick && (s_r.pre_cnt == pre_last) && !ckif.restart;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// [rtl/dpm_pwm.sv]
// Dual-output pulse width modulator with mode, clock and, in the 16-bit modes, double-buffered data control
module dpm_pwm (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic core_div_tick,
    input wire logic external_count_input,
    input wire logic alt_pins,
    output logic output0_primary_pin,
    output logic output0_primary_oe,
    output logic output1_primary_pin,
    output logic output1_primary_oe,
    output logic output0_alternate_pin,
    output logic output0_alternate_oe,
    output logic output1_alternate_pin,
    output logic output1_alternate_oe
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [1:0][7:0] hold;
        logic [1:0][15:0] pend_val;
        logic [1:0] pend;
        logic [1:0][15:0] act;
        logic [15:0] cnt;
        logic [7:0] cnt_b;
        logic [1:0][15:0] acc;
        logic [1:0] sd;
        logic rz_on;
        logic out0;
        logic out1;
        logic en0;
        logic en1;
        logic [7:0] rdata;
    } dpm_state_type;

    dpm_state_type s_r;
    dpm_state_type s_nxt;
    dpm_clk_if ckif ();
    logic [2:0] mode;
    logic is16;
    logic last;
    logic last_b;
    logic ctrl_wr;
    logic [16:0] sum0;
    logic [16:0] sum1;

    dpm_tick_gen u_tick (
        .core_clk(core_clk),
        .rst(rst),
        .ext_count_input(external_count_input),
        .core_div_tick(core_div_tick),
        .ckif(ckif)
    );

    assign ctrl_wr = sfr_wr && (sfr_addr == dpm_pkg::CTRL_ADDR);
    assign ckif.clock_source = s_r.ctrl[dpm_pkg::CSRC_LSB +: 2];
    assign ckif.prescale = s_r.ctrl[dpm_pkg::PRESC_LSB +: 2];
    assign ckif.restart = ctrl_wr;

    // ==========================================
    // Mode decode and cycle end
    always_comb begin
        mode = s_r.ctrl[dpm_pkg::MODE_LSB +: 3];
        // Reserved code falls back to off
        if (mode == dpm_pkg::MODE_RESERVED) begin
            mode = dpm_pkg::MODE_OFF;
        end
        is16 = (mode == dpm_pkg::MODE_SINGLE) || (mode == dpm_pkg::MODE_TWIN16) ||
               (mode == dpm_pkg::MODE_SD_NRZ) || (mode == dpm_pkg::MODE_SD_RZ);
        unique case (mode)
            dpm_pkg::MODE_SINGLE: last = (s_r.cnt == s_r.act[1] - dpm_pkg::ONE16);
            dpm_pkg::MODE_TWIN8, dpm_pkg::MODE_DUAL8: last = (s_r.cnt[7:0] == s_r.act[1][7:0]);
            default: last = (s_r.cnt == dpm_pkg::CNT_FULL_LAST);
        endcase
        last_b = (s_r.cnt_b == s_r.act[1][15:8]);
        sum0 = {1'b0, s_r.acc[0]} + {1'b0, s_r.act[0]};
        sum1 = {1'b0, s_r.acc[1]} + {1'b0, s_r.act[1]};
    end

    // ==========================================
    // Next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.rz_on = ckif.tick;
        if (ckif.tick) begin
            if (mode == dpm_pkg::MODE_OFF) begin
                s_nxt.cnt = 16'h0000;
                s_nxt.cnt_b = 8'h00;
            end else begin
                s_nxt.cnt = last ? 16'h0000 : s_r.cnt + dpm_pkg::ONE16;
                s_nxt.cnt_b = last_b ? 8'h00 : s_r.cnt_b + 8'h01;
            end
            s_nxt.acc[0] = sum0[15:0];
            s_nxt.acc[1] = sum1[15:0];
            s_nxt.sd = {sum1[16], sum0[16]};
            // In the 16-bit modes new duty values wait for the end of the running cycle
            if (is16 && last) begin
                for (int i = 0; i < 2; i++) begin
                    if (s_r.pend[i]) begin
                        s_nxt.act[i] = s_r.pend_val[i];
                        s_nxt.pend[i] = 1'b0;
                    end
                end
            end
        end
        if (sfr_wr) begin
            unique case (sfr_addr)
                dpm_pkg::CTRL_ADDR: s_nxt.ctrl = sfr_wdata;
                dpm_pkg::DUTY0_LO_ADDR, dpm_pkg::DUTY1_LO_ADDR: begin
                    if (is16) begin
                        s_nxt.hold[sfr_addr[1]] = sfr_wdata;
                    end else begin
                        s_nxt.act[sfr_addr[1]][7:0] = sfr_wdata;
                    end
                end
                dpm_pkg::DUTY0_HI_ADDR, dpm_pkg::DUTY1_HI_ADDR: begin
                    if (is16) begin
                        // Written after the commit so a same-cycle write is kept
                        s_nxt.pend_val[sfr_addr[2]] = {sfr_wdata, s_r.hold[sfr_addr[2]]};
                        s_nxt.pend[sfr_addr[2]] = 1'b1;
                    end else begin
                        s_nxt.act[sfr_addr[2]][15:8] = sfr_wdata;
                    end
                end
                default: ;
            endcase
        end
        if (ctrl_wr) begin
            s_nxt.cnt = 16'h0000;
            s_nxt.cnt_b = 8'h00;
            s_nxt.acc = '0;
            s_nxt.sd = 2'b00;
        end
        // Waveforms per mode
        s_nxt.out0 = 1'b0;
        s_nxt.out1 = 1'b0;
        unique case (mode)
            dpm_pkg::MODE_SINGLE: s_nxt.out1 = s_r.cnt < s_r.act[0];
            dpm_pkg::MODE_TWIN8: begin
                s_nxt.out0 = s_r.cnt[7:0] < s_r.act[0][7:0];
                s_nxt.out1 = (s_r.cnt[7:0] >= s_r.act[1][15:8]) && (s_r.cnt[7:0] < s_r.act[0][15:8]);
            end
            dpm_pkg::MODE_TWIN16: begin
                s_nxt.out0 = s_r.cnt < s_r.act[0];
                s_nxt.out1 = s_r.cnt < s_r.act[1];
            end
            dpm_pkg::MODE_SD_NRZ: {s_nxt.out1, s_nxt.out0} = s_r.sd;
            dpm_pkg::MODE_DUAL8: begin
                s_nxt.out0 = s_r.cnt[7:0] < s_r.act[0][7:0];
                s_nxt.out1 = s_r.cnt_b < s_r.act[0][15:8];
            end
            // Return to zero: high for only one core cycle per tick
            dpm_pkg::MODE_SD_RZ: {s_nxt.out1, s_nxt.out0} = s_r.sd & {2{s_r.rz_on}};
            default: ;
        endcase
        s_nxt.en1 = (mode != dpm_pkg::MODE_OFF);
        s_nxt.en0 = (mode != dpm_pkg::MODE_OFF) && (mode != dpm_pkg::MODE_SINGLE) &&
                    !s_r.ctrl[dpm_pkg::FIRST_OFF_BIT];
        unique case (sfr_addr)
            dpm_pkg::CTRL_ADDR: s_nxt.rdata = s_r.ctrl;
            dpm_pkg::DUTY0_LO_ADDR: s_nxt.rdata = s_r.act[0][7:0];
            dpm_pkg::DUTY0_HI_ADDR: s_nxt.rdata = s_r.act[0][15:8];
            dpm_pkg::DUTY1_LO_ADDR: s_nxt.rdata = s_r.act[1][7:0];
            dpm_pkg::DUTY1_HI_ADDR: s_nxt.rdata = s_r.act[1][15:8];
            default: s_nxt.rdata = dpm_pkg::UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
            s_r.ctrl <= dpm_pkg::CTRL_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================
    // Pin routing
    assign output0_primary_pin = s_r.out0;
    assign output0_alternate_pin = s_r.out0;
    assign output1_primary_pin = s_r.out1;
    assign output1_alternate_pin = s_r.out1;
    assign output0_primary_oe = s_r.en0 && !alt_pins;
    assign output1_primary_oe = s_r.en1 && !alt_pins;
    assign output0_alternate_oe = s_r.en0 && alt_pins;
    assign output1_alternate_oe = s_r.en1 && alt_pins;
    assign sfr_rdata = s_r.rdata;
endmodule

// [verif/dpm_pwm_checker.sv]
// Port-level assertions for the dual-output modulator
module dpm_pwm_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic alt_pins,
    input wire logic output0_primary_oe,
    input wire logic output1_primary_oe,
    input wire logic output0_alternate_oe,
    input wire logic output1_alternate_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================
    // Helper state
    logic [2:0] mode_r;
    logic cw;
    logic oe0;
    logic oe1;
    assign cw = sfr_wr && sfr_addr == dpm_pkg::CTRL_ADDR;
    assign oe0 = output0_primary_oe || output0_alternate_oe;
    assign oe1 = output1_primary_oe || output1_alternate_oe;
    // Mirrors the mode so the buffered-write check knows when it applies
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mode_r <= dpm_pkg::MODE_OFF;
        end else if (cw) begin
            mode_r <= sfr_wdata[6:4];
        end
    end
    // ==========================================
    // Assertions
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Enables are registered from the control register, so they follow a write by two edges
    off_modes_quiet_a: assert property (cw && sfr_wdata[6:4] inside {3'h0, 3'h7} |-> ##2 !oe0 && !oe1)
        else $error("pin driven in an off mode");
    single_first_free_a: assert property (cw && sfr_wdata[6:4] == dpm_pkg::MODE_SINGLE |-> ##2 !oe0 && oe1)
        else $error("single mode drives the wrong pins");
    first_off_bit_a: assert property (cw && sfr_wdata[dpm_pkg::FIRST_OFF_BIT] |-> ##2 !oe0)
        else $error("first output still driven");
    dual_drive_a: assert property (cw && !sfr_wdata[7] && sfr_wdata[6:4] inside {[3'h2:3'h6]} |-> ##2 oe0 && oe1)
        else $error("dual mode leaves a pin undriven");
    primary_route_a: assert property ((output0_primary_oe || output1_primary_oe) |-> !alt_pins)
        else $error("primary pin driven while alternate chosen");
    alt_route_a: assert property ((output0_alternate_oe || output1_alternate_oe) |-> alt_pins)
        else $error("alternate pin driven while primary chosen");
    ctrl_readback_a: assert property (cw ##1 (sfr_addr == dpm_pkg::CTRL_ADDR && !sfr_wr) |=>
        sfr_rdata == $past(sfr_wdata, 2)) else $error("control readback wrong");
    held_low_hidden_a: assert property (sfr_wr && sfr_addr == dpm_pkg::DUTY0_LO_ADDR &&
        mode_r inside {3'h1, 3'h3, 3'h4, 3'h6} ##1 (sfr_addr == dpm_pkg::DUTY0_LO_ADDR && !sfr_wr)
        |=> $stable(sfr_rdata)) else $error("held low byte visible at once");
endmodule

// [verif/dpm_load.sv]
// Pin load model: pull-down on every modulator pin
module dpm_load (
    input wire logic [3:0] pin,
    input wire logic [3:0] oe,
    output logic [3:0] level
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================
    // Released pins fall to the pull-down, never keep the last level
    assign level = pin & oe;
endmodule

// [verif/tb.sv]
// Self-checking bench for the dual-output modulator
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk, rst, sfr_wr, core_div_tick, external_count_input, alt_pins, out0, out1;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [3:0] pin, oe, lv;
    int n_fail = 0;
    int checked = 0;
    int ec = 0;
    dpm_pwm dut_u (.core_clk(core_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .core_div_tick(core_div_tick), .external_count_input(external_count_input),
        .alt_pins(alt_pins), .output0_primary_pin(pin[0]), .output0_primary_oe(oe[0]),
        .output1_primary_pin(pin[1]), .output1_primary_oe(oe[1]), .output0_alternate_pin(pin[2]),
        .output0_alternate_oe(oe[2]), .output1_alternate_pin(pin[3]), .output1_alternate_oe(oe[3]));
    dpm_load load_u (.pin(pin), .oe(oe), .level(lv));
    assign out0 = alt_pins ? lv[2] : lv[0];
    assign out1 = alt_pins ? lv[3] : lv[1];
    // ==========================================
    // Clocks and tick sources
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // Divider tick every other cycle, external clock period six cycles
    always @(posedge core_clk) begin
        #1;
        core_div_tick = ~core_div_tick;
        ec = (ec + 1) % 3;
        if (ec == 0) external_count_input = ~external_count_input;
    end
    // ==========================================
    // Shared tasks
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, d);
        @(posedge core_clk);
        #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge core_clk);
        #1;
        sfr_wr = 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        #1;
        sfr_addr = a;
        repeat (2) @(posedge core_clk);
        #1;
        d = sfr_rdata;
    endtask
    // Window lengths are whole periods, or far shorter than one in the free-running 16-bit case, so the counts do not depend on phase
    task automatic measure(input int w, output int h0, h1, r0);
        logic p;
        #1;
        h0 = 0;
        h1 = 0;
        r0 = 0;
        p = out0;
        repeat (w) begin
            @(posedge core_clk);
            #1;
            if (out0 === 1'b1 && p !== 1'b1) r0++;
            if (out0 === 1'b1) h0++;
            if (out1 === 1'b1) h1++;
            p = out0;
        end
    endtask
    // Data goes in through the unbuffered 8-bit mode, then the mode under test
    task automatic run_case(input logic [7:0] c, input logic [15:0] d0, d1, input int w, e0, e1, ee);
        int h0, h1, r0;
        wr_reg(dpm_pkg::CTRL_ADDR, 8'h23);
        wr_reg(dpm_pkg::DUTY0_LO_ADDR, d0[7:0]);
        wr_reg(dpm_pkg::DUTY0_HI_ADDR, d0[15:8]);
        wr_reg(dpm_pkg::DUTY1_LO_ADDR, d1[7:0]);
        wr_reg(dpm_pkg::DUTY1_HI_ADDR, d1[15:8]);
        wr_reg(dpm_pkg::CTRL_ADDR, c);
        repeat (300) @(posedge core_clk);
        measure(w, h0, h1, r0);
        chk("out0 high cycles", e0[15:0], h0[15:0]);
        chk("out1 high cycles", e1[15:0], h1[15:0]);
        if (ee > 0) chk("out0 rising edges", ee[15:0], r0[15:0]);
    endtask
    // ==========================================
    // Scenarios
    task automatic test_regs();
        logic [7:0] v;
        rd_reg(dpm_pkg::CTRL_ADDR, v);
        chk("control reset", {8'h00, dpm_pkg::CTRL_RESET}, {8'h00, v});
        rd_reg(dpm_pkg::DUTY1_HI_ADDR, v);
        chk("data reset", {8'h00, dpm_pkg::DATA_RESET}, {8'h00, v});
        wr_reg(8'haf, 8'h55);
        rd_reg(8'h00, v);
        chk("unmapped read", {8'h00, dpm_pkg::UNMAPPED_READ}, {8'h00, v});
        rd_reg(dpm_pkg::CTRL_ADDR, v);
        chk("control after stray write", {8'h00, dpm_pkg::CTRL_RESET}, {8'h00, v});
    endtask
    task automatic test_clocks();
        logic [7:0] cs [7] = '{8'h43, 8'h47, 8'h4b, 8'h4f, 8'h41, 8'h40, 8'h42};
        int en [7] = '{960, 240, 60, 15, 480, 32, 160};
        for (int i = 0; i < 7; i++) begin
            run_case(cs[i], 16'h4000, 16'h4000, 3840, 960, 960, en[i]);
        end
    endtask
    task automatic test_modes();
        alt_pins = 1'b1;
        run_case(8'h23, 16'h0703, 16'h0209, 100, 30, 50, 0);
        alt_pins = 1'b0;
        run_case(8'h53, 16'h0203, 16'h0409, 100, 30, 40, 0);
        run_case(8'h43, 16'h4000, 16'h8000, 100, 25, 50, 0);
        run_case(8'h67, 16'h8000, 16'h4000, 160, 20, 10, 0);
        run_case(8'hb3, 16'hffff, 16'hffff, 100, 0, 100, 0);
        run_case(8'h03, 16'h0005, 16'h0005, 100, 0, 0, 0);
        run_case(8'h73, 16'h0005, 16'h0005, 100, 0, 0, 0);
        run_case(8'h13, 16'h0003, 16'h000a, 100, 0, 30, 0);
    endtask
    // Rewriting control every five cycles keeps the count in 0..4
    task automatic test_restart();
        int h;
        h = 0;
        for (int i = 0; i < 120; i++) begin
            @(posedge core_clk);
            #1;
            if (i >= 20 && out1 === 1'b1) h++;
            sfr_addr = dpm_pkg::CTRL_ADDR;
            sfr_wdata = 8'h13;
            sfr_wr = (i % 5 == 0);
        end
        chk("high cycles under restarts", 16'd60, h[15:0]);
    endtask
    task automatic test_buffer();
        logic [7:0] v;
        int h0, h1, r0;
        wr_reg(dpm_pkg::DUTY0_LO_ADDR, 8'h05);
        rd_reg(dpm_pkg::DUTY0_LO_ADDR, v);
        chk("held low readback", 16'h0003, {8'h00, v});
        wr_reg(dpm_pkg::DUTY0_HI_ADDR, 8'h00);
        repeat (20) @(posedge core_clk);
        rd_reg(dpm_pkg::DUTY0_LO_ADDR, v);
        chk("committed low readback", 16'h0005, {8'h00, v});
        measure(100, h0, h1, r0);
        chk("out1 high after commit", 16'd50, h1[15:0]);
    endtask
    // ==========================================
    // Main sequence and watchdog
    initial begin
        rst = 1'b1;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        alt_pins = 1'b0;
        core_div_tick = 1'b0;
        external_count_input = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        rst = 1'b0;
        test_regs();
        test_clocks();
        test_modes();
        test_restart();
        test_buffer();
        report_and_stop();
    end
    // Tests need about 33000 cycles; the limit leaves some margin
    initial begin
        #1000000;
        n_fail++;
        report_and_stop();
    end
endmodule
bind dpm_pwm dpm_pwm_checker chk_u (.core_clk, .rst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata, .alt_pins,
    .output0_primary_oe, .output1_primary_oe, .output0_alternate_oe, .output1_alternate_oe);
